//--- hdl/svm_dwell.v
// Purpose: window dwell qualifier, counts control cycles spent inside a window
// Assumes: tick_in pulses once per control cycle
// Notes: leaving the window restarts the count at once
`timescale 1ns/1ps
module svm_dwell #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // control
  input wire tick_in,
  input wire inside_in,
  input wire [CNT_W-1:0] dwell_in,
  // result
  output reg met_out
);
  reg [CNT_W-1:0] cnt_reg;

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= {CNT_W{1'b0}};
      met_out <= 1'b0;
    end else if (tick_in) begin
      if (!inside_in) begin
        cnt_reg <= {CNT_W{1'b0}};
        met_out <= 1'b0;
      end else if (cnt_reg >= dwell_in) begin
        met_out <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // svm_dwell

//--- hdl/svm_ramp.v
// Purpose: rate-limited speed setpoint used while homing
// Assumes: step_in is the largest change allowed per control cycle
// Notes: a zero step freezes the setpoint, so software must keep it nonzero
`timescale 1ns/1ps
module svm_ramp #(
  parameter W = 32
) (
  // clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // control
  input wire tick_in,
  input wire [W-1:0] target_in,
  input wire [W-1:0] step_in,
  // result
  output reg [W-1:0] speed_out
);
  wire [W-1:0] diff_up = target_in - speed_out;
  wire [W-1:0] diff_dn = speed_out - target_in;

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      speed_out <= {W{1'b0}};
    end else if (tick_in) begin
      if (target_in > speed_out) begin
        speed_out <= (diff_up > step_in) ? speed_out + step_in : target_in;
      end else if (target_in < speed_out) begin
        speed_out <= (diff_dn > step_in) ? speed_out - step_in : target_in;
      end
    end
  end
endmodule // svm_ramp

//--- hdl/svm_regs.vh
// Purpose: constants for the servo motion supervision block
// Assumes: one control clock at 250 MHz; register port uses 16-bit offsets
// Notes: offsets are byte-free register addresses as used on the parameter port
`ifndef SVM_REGS_VH
`define SVM_REGS_VH

`define SVM_CLK_PERIOD_NS 4
`define SVM_CTRL_CYCLE_NS 1000000

`define SVM_ADR_ZERO_WIN 16'h0980
`define SVM_ADR_LIMIT_ACT 16'h0990
`define SVM_ADR_REACH_TIME 16'h1990
`define SVM_ADR_FOLLOW_LIM 16'h3800
`define SVM_ADR_POS_WIN 16'h3900
`define SVM_ADR_HOME_OFS 16'h4100
`define SVM_ADR_SOFT_UP 16'h4410
`define SVM_ADR_SOFT_LO 16'h4420
`define SVM_ADR_HOME_METH 16'h4d00
`define SVM_ADR_HOME_TURN 16'h5010
`define SVM_ADR_HOME_SRCH 16'h5020
`define SVM_ADR_HOME_MODE 16'h5050
`define SVM_ADR_HOME_ACC 16'h5200
`define SVM_ADR_VEL_KP 16'h6310
`define SVM_ADR_VEL_KI 16'h6320
`define SVM_ADR_VEL_FILT 16'h6350
`define SVM_ADR_VEL_KIF 16'h6370
`define SVM_ADR_SPD_WIN 16'h63a0
`define SVM_ADR_ZERO_TIME 16'h6440
`define SVM_ADR_POS_KP 16'h6810
`define SVM_ADR_POS_KVFF 16'h6820
`define SVM_ADR_POS_KAFF 16'h6830
`define SVM_ADR_SMOOTH 16'h6850

`define SVM_RST_ZERO_WIN 16'h0003
`define SVM_RST_LIMIT_ACT 8'h01
`define SVM_RST_REACH_TIME 16'h000a
`define SVM_RST_FOLLOW_LIM 32'h00080000
`define SVM_RST_POS_WIN 32'h00000147
`define SVM_RST_HOME_TURN 32'h0000012c
`define SVM_RST_HOME_SRCH 32'h00000064
`define SVM_RST_HOME_ACC 32'h00000032
`define SVM_RST_VEL_KP 16'h0004
`define SVM_RST_VEL_KI 16'h0000
`define SVM_RST_VEL_FILT 8'hf0
`define SVM_RST_VEL_KIF 16'h0002
`define SVM_RST_SPD_WIN 32'h0002bb0c
`define SVM_RST_ZERO_TIME 16'h000a
`define SVM_RST_POS_KP 16'h000a
`define SVM_RST_POS_KVFF 16'h0064
`define SVM_RST_POS_KAFF 16'h7fff
`define SVM_RST_SMOOTH 16'h0001

`define SVM_LIMIT_ACT_ALARM 8'h00
`define SVM_HOME_MODE_OFFSET 8'h00
`define SVM_HOME_MODE_TRIGGER 8'h01

`define SVM_FILT_BW_SCALE 16'h0014
`define SVM_FILT_BW_BASE 16'h0064
`define SVM_KI_FINE_SHIFT 5
`define SVM_KVFF_SHIFT 7
`define SVM_KAFF_SHIFT 15

`endif

//--- hdl/svm_top.v
// Purpose: motion supervision, homing setpoints and loop parameter block
// Assumes: motion inputs synchronous to core_clk_in; one write or read per cycle
// Notes: one control cycle lasts one millisecond, counted from the core clock
`timescale 1ns/1ps
`include "svm_regs.vh"
module svm_top #(
  parameter CTRL_CYCLES = `SVM_CTRL_CYCLE_NS / `SVM_CLK_PERIOD_NS
) (
  // clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // parameter port
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_wdata_in,
  output reg [31:0] reg_rdata_out,
  output reg reg_ack_out,
  output reg reg_err_out,
  // motion feedback and command
  input wire [31:0] cmd_pos_in,
  input wire [31:0] act_pos_in,
  input wire [31:0] target_speed_in,
  input wire [31:0] act_speed_in,
  input wire [31:0] target_accel_in,
  input wire drive_enabled_in,
  // limits and homing events
  input wire pos_limit_in,
  input wire neg_limit_in,
  input wire home_found_in,
  input wire homing_active_in,
  input wire home_trigger_in,
  input wire home_done_in,
  input wire alarm_clear_in,
  // supervision results
  output reg following_alarm_out,
  output wire pos_reached_out,
  output reg speed_reached_out,
  output wire zero_speed_out,
  output reg limit_alarm_out,
  output reg soft_limit_pos_out,
  output reg soft_limit_neg_out,
  // homing results
  output wire [31:0] home_speed_out,
  output reg [31:0] home_target_pos_out,
  output reg [31:0] report_pos_out,
  output wire [7:0] home_method_out,
  // loop parameters
  output wire [15:0] vel_kp_out,
  output reg [21:0] vel_ki_out,
  output reg [15:0] vel_filter_bw_out,
  output reg [31:0] pos_loop_cmd_out,
  output wire [15:0] smooth_filter_out
);
  // parameter registers
  reg [15:0] zero_speed_window_reg;
  reg [7:0] limit_action_select_reg;
  reg [15:0] reach_time_window_reg;
  reg [31:0] following_error_limit_reg;
  reg [31:0] target_position_window_reg;
  reg [31:0] home_offset_value_reg;
  reg [31:0] soft_limit_upper_reg;
  reg [31:0] soft_limit_lower_reg;
  reg [7:0] home_method_select_reg;
  reg [31:0] home_post_trigger_speed_reg;
  reg [31:0] home_search_speed_reg;
  reg [7:0] home_offset_behaviour_reg;
  reg [31:0] home_acceleration_reg;
  reg [15:0] velocity_prop_gain_reg;
  reg [15:0] velocity_integral_gain_reg;
  reg [7:0] velocity_filter_setting_reg;
  reg [15:0] velocity_integral_fine_reg;
  reg [31:0] speed_reached_window_reg;
  reg [15:0] zero_speed_dwell_time_reg;
  reg [15:0] position_prop_gain_reg;
  reg [15:0] velocity_feedforward_gain_reg;
  reg [15:0] accel_feedforward_gain_reg;
  reg [15:0] position_smoothing_filter_reg;

  // control cycle and supervision state
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg pos_inside_reg;
  reg zero_inside_reg;
  reg trigger_seen_reg;
  reg [31:0] trigger_pos_reg;
  reg [31:0] pos_ref_reg;
  reg [31:0] rdata_next;
  reg hit_next;

  // control cycle strobe
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == CTRL_CYCLES - 1) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg <= 1'b0;
    end
  end

  // parameter writes
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zero_speed_window_reg <= `SVM_RST_ZERO_WIN;
      limit_action_select_reg <= `SVM_RST_LIMIT_ACT;
      reach_time_window_reg <= `SVM_RST_REACH_TIME;
      following_error_limit_reg <= `SVM_RST_FOLLOW_LIM;
      target_position_window_reg <= `SVM_RST_POS_WIN;
      home_offset_value_reg <= 32'h00000000;
      soft_limit_upper_reg <= 32'h00000000;
      soft_limit_lower_reg <= 32'h00000000;
      home_method_select_reg <= 8'h00;
      home_post_trigger_speed_reg <= `SVM_RST_HOME_TURN;
      home_search_speed_reg <= `SVM_RST_HOME_SRCH;
      home_offset_behaviour_reg <= `SVM_HOME_MODE_OFFSET;
      home_acceleration_reg <= `SVM_RST_HOME_ACC;
      velocity_prop_gain_reg <= `SVM_RST_VEL_KP;
      velocity_integral_gain_reg <= `SVM_RST_VEL_KI;
      velocity_filter_setting_reg <= `SVM_RST_VEL_FILT;
      velocity_integral_fine_reg <= `SVM_RST_VEL_KIF;
      speed_reached_window_reg <= `SVM_RST_SPD_WIN;
      zero_speed_dwell_time_reg <= `SVM_RST_ZERO_TIME;
      position_prop_gain_reg <= `SVM_RST_POS_KP;
      velocity_feedforward_gain_reg <= `SVM_RST_POS_KVFF;
      accel_feedforward_gain_reg <= `SVM_RST_POS_KAFF;
      position_smoothing_filter_reg <= `SVM_RST_SMOOTH;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `SVM_ADR_ZERO_WIN: zero_speed_window_reg <= reg_wdata_in[15:0];
        `SVM_ADR_LIMIT_ACT: limit_action_select_reg <= reg_wdata_in[7:0];
        `SVM_ADR_REACH_TIME: reach_time_window_reg <= reg_wdata_in[15:0];
        `SVM_ADR_FOLLOW_LIM: following_error_limit_reg <= reg_wdata_in;
        `SVM_ADR_POS_WIN: target_position_window_reg <= reg_wdata_in;
        `SVM_ADR_HOME_OFS: home_offset_value_reg <= reg_wdata_in;
        `SVM_ADR_SOFT_UP: soft_limit_upper_reg <= reg_wdata_in;
        `SVM_ADR_SOFT_LO: soft_limit_lower_reg <= reg_wdata_in;
        `SVM_ADR_HOME_METH: home_method_select_reg <= reg_wdata_in[7:0];
        `SVM_ADR_HOME_TURN: home_post_trigger_speed_reg <= reg_wdata_in;
        `SVM_ADR_HOME_SRCH: home_search_speed_reg <= reg_wdata_in;
        `SVM_ADR_HOME_MODE: home_offset_behaviour_reg <= reg_wdata_in[7:0];
        `SVM_ADR_HOME_ACC: home_acceleration_reg <= reg_wdata_in;
        `SVM_ADR_VEL_KP: velocity_prop_gain_reg <= reg_wdata_in[15:0];
        `SVM_ADR_VEL_KI: velocity_integral_gain_reg <= reg_wdata_in[15:0];
        `SVM_ADR_VEL_FILT: velocity_filter_setting_reg <= reg_wdata_in[7:0];
        `SVM_ADR_VEL_KIF: velocity_integral_fine_reg <= reg_wdata_in[15:0];
        `SVM_ADR_SPD_WIN: speed_reached_window_reg <= reg_wdata_in;
        `SVM_ADR_ZERO_TIME: zero_speed_dwell_time_reg <= reg_wdata_in[15:0];
        `SVM_ADR_POS_KP: position_prop_gain_reg <= reg_wdata_in[15:0];
        `SVM_ADR_POS_KVFF: velocity_feedforward_gain_reg <= reg_wdata_in[15:0];
        `SVM_ADR_POS_KAFF: accel_feedforward_gain_reg <= reg_wdata_in[15:0];
        `SVM_ADR_SMOOTH: begin
          // a live filter change would kick the command, so enabled writes drop
          if (!drive_enabled_in) begin
            position_smoothing_filter_reg <= reg_wdata_in[15:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read mux and unmapped detection
  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b1;
    case (reg_addr_in)
      `SVM_ADR_ZERO_WIN: rdata_next = {16'h0000, zero_speed_window_reg};
      `SVM_ADR_LIMIT_ACT: rdata_next = {24'h000000, limit_action_select_reg};
      `SVM_ADR_REACH_TIME: rdata_next = {16'h0000, reach_time_window_reg};
      `SVM_ADR_FOLLOW_LIM: rdata_next = following_error_limit_reg;
      `SVM_ADR_POS_WIN: rdata_next = target_position_window_reg;
      `SVM_ADR_HOME_OFS: rdata_next = home_offset_value_reg;
      `SVM_ADR_SOFT_UP: rdata_next = soft_limit_upper_reg;
      `SVM_ADR_SOFT_LO: rdata_next = soft_limit_lower_reg;
      `SVM_ADR_HOME_METH: rdata_next = {24'h000000, home_method_select_reg};
      `SVM_ADR_HOME_TURN: rdata_next = home_post_trigger_speed_reg;
      `SVM_ADR_HOME_SRCH: rdata_next = home_search_speed_reg;
      `SVM_ADR_HOME_MODE: rdata_next = {24'h000000, home_offset_behaviour_reg};
      `SVM_ADR_HOME_ACC: rdata_next = home_acceleration_reg;
      `SVM_ADR_VEL_KP: rdata_next = {16'h0000, velocity_prop_gain_reg};
      `SVM_ADR_VEL_KI: rdata_next = {16'h0000, velocity_integral_gain_reg};
      `SVM_ADR_VEL_FILT: rdata_next = {24'h000000, velocity_filter_setting_reg};
      `SVM_ADR_VEL_KIF: rdata_next = {16'h0000, velocity_integral_fine_reg};
      `SVM_ADR_SPD_WIN: rdata_next = speed_reached_window_reg;
      `SVM_ADR_ZERO_TIME: rdata_next = {16'h0000, zero_speed_dwell_time_reg};
      `SVM_ADR_POS_KP: rdata_next = {16'h0000, position_prop_gain_reg};
      `SVM_ADR_POS_KVFF: rdata_next = {16'h0000, velocity_feedforward_gain_reg};
      `SVM_ADR_POS_KAFF: rdata_next = {16'h0000, accel_feedforward_gain_reg};
      `SVM_ADR_SMOOTH: rdata_next = {16'h0000, position_smoothing_filter_reg};
      default: hit_next = 1'b0;
    endcase
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h00000000;
      reg_ack_out <= 1'b0;
      reg_err_out <= 1'b0;
    end else begin
      reg_ack_out <= reg_rd_in | reg_wr_in;
      reg_err_out <= (reg_rd_in | reg_wr_in) & ~hit_next;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_next;
      end
    end
  end

  // error magnitudes, 33 bits so that full-scale differences never wrap
  wire signed [32:0] pos_err_s = $signed({cmd_pos_in[31], cmd_pos_in}) -
                                 $signed({act_pos_in[31], act_pos_in});
  wire [32:0] pos_err_abs = pos_err_s[32] ? (~pos_err_s + 33'h000000001) : pos_err_s;
  wire signed [32:0] spd_err_s = $signed({act_speed_in[31], act_speed_in}) -
                                 $signed({target_speed_in[31], target_speed_in});
  wire [32:0] spd_err_abs = spd_err_s[32] ? (~spd_err_s + 33'h000000001) : spd_err_s;
  wire [32:0] spd_abs = act_speed_in[31] ? ({1'b0, ~act_speed_in} + 33'h000000001)
                                         : {1'b0, act_speed_in};
  wire pos_inside = pos_err_abs <= {1'b0, target_position_window_reg};
  // a negative speed window can never be met
  wire spd_inside = ~speed_reached_window_reg[31] &
                    (spd_err_abs <= {1'b0, speed_reached_window_reg});
  wire zero_inside = spd_abs <= {17'h00000, zero_speed_window_reg};
  wire soft_en = $signed(soft_limit_upper_reg) > $signed(soft_limit_lower_reg);

  // supervision, sampled once per control cycle
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      following_alarm_out <= 1'b0;
      speed_reached_out <= 1'b0;
      limit_alarm_out <= 1'b0;
      soft_limit_pos_out <= 1'b0;
      soft_limit_neg_out <= 1'b0;
      pos_inside_reg <= 1'b0;
      zero_inside_reg <= 1'b0;
    end else begin
      if (tick_reg) begin
        pos_inside_reg <= pos_inside;
        zero_inside_reg <= zero_inside;
        speed_reached_out <= spd_inside;
        soft_limit_pos_out <= soft_en & ($signed(act_pos_in) > $signed(soft_limit_upper_reg));
        soft_limit_neg_out <= soft_en & ($signed(act_pos_in) < $signed(soft_limit_lower_reg));
      end
      // alarms are sticky; a new event beats a clear in the same cycle
      if (tick_reg && pos_err_abs > {1'b0, following_error_limit_reg}) begin
        following_alarm_out <= 1'b1;
      end else if (alarm_clear_in) begin
        following_alarm_out <= 1'b0;
      end
      if (tick_reg && home_found_in && (pos_limit_in || neg_limit_in) &&
          limit_action_select_reg == `SVM_LIMIT_ACT_ALARM) begin
        limit_alarm_out <= 1'b1;
      end else if (alarm_clear_in) begin
        limit_alarm_out <= 1'b0;
      end
    end
  end

  svm_dwell #(
    .CNT_W(16)
  ) u_pos_dwell (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_reg),
    .inside_in(pos_inside_reg),
    .dwell_in(reach_time_window_reg),
    .met_out(pos_reached_out)
  );

  svm_dwell #(
    .CNT_W(16)
  ) u_zero_dwell (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_reg),
    .inside_in(zero_inside_reg),
    .dwell_in(zero_speed_dwell_time_reg),
    .met_out(zero_speed_out)
  );

  // homing: speed phase, trigger capture and position reference
  wire [31:0] home_target_speed = !homing_active_in ? 32'h00000000 :
                                  trigger_seen_reg ? home_post_trigger_speed_reg :
                                  home_search_speed_reg;

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trigger_seen_reg <= 1'b0;
      trigger_pos_reg <= 32'h00000000;
      home_target_pos_out <= 32'h00000000;
      pos_ref_reg <= 32'h00000000;
    end else begin
      if (!homing_active_in) begin
        trigger_seen_reg <= 1'b0;
      end else if (home_trigger_in && !trigger_seen_reg) begin
        trigger_seen_reg <= 1'b1;
        trigger_pos_reg <= act_pos_in;
        if (home_offset_behaviour_reg == `SVM_HOME_MODE_OFFSET) begin
          home_target_pos_out <= act_pos_in + home_offset_value_reg;
        end else begin
          home_target_pos_out <= act_pos_in;
        end
      end
      if (home_done_in) begin
        if (home_offset_behaviour_reg == `SVM_HOME_MODE_OFFSET) begin
          pos_ref_reg <= act_pos_in;
        end else begin
          pos_ref_reg <= act_pos_in + home_offset_value_reg;
        end
      end
    end
  end

  svm_ramp #(
    .W(32)
  ) u_home_ramp (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_reg),
    .target_in(home_target_speed),
    .step_in(home_acceleration_reg),
    .speed_out(home_speed_out)
  );

  // loop terms; products are wide and the command wraps, it does not saturate
  wire signed [48:0] kpp_term = pos_err_s * $signed(position_prop_gain_reg);
  wire signed [47:0] kvff_term = $signed(target_speed_in) *
                                 $signed(velocity_feedforward_gain_reg);
  wire signed [47:0] kaff_term = $signed(target_accel_in) *
                                 $signed(accel_feedforward_gain_reg);
  wire signed [49:0] loop_sum = kpp_term + (kvff_term >>> `SVM_KVFF_SHIFT) +
                                (kaff_term >>> `SVM_KAFF_SHIFT);

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      report_pos_out <= 32'h00000000;
      vel_ki_out <= 22'h000000;
      vel_filter_bw_out <= 16'h0000;
      pos_loop_cmd_out <= 32'h00000000;
    end else begin
      report_pos_out <= act_pos_in - pos_ref_reg;
      vel_ki_out <= ({velocity_integral_gain_reg, 6'h00} >> 1) +
                    {6'h00, velocity_integral_fine_reg};
      vel_filter_bw_out <= {8'h00, velocity_filter_setting_reg} * `SVM_FILT_BW_SCALE +
                           `SVM_FILT_BW_BASE;
      pos_loop_cmd_out <= loop_sum[31:0];
    end
  end

  assign vel_kp_out = velocity_prop_gain_reg;
  assign home_method_out = home_method_select_reg;
  assign smooth_filter_out = position_smoothing_filter_reg;
endmodule // svm_top

//--- tb/svm_master.sv
// Purpose: parameter-port master standing in for the fieldbus side
// Assumes: one strobe per access, answer one cycle later
// Notes: smoothing writes while enabled are held back unless bad_ok is set
`timescale 1ns/1ps
module svm_master (
  // clock and drive state
  input wire clk_in,
  input wire drive_en_in,
  // parameter port
  output logic [15:0] addr_out = 16'h0,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic [31:0] wdata_out = 32'h0,
  input wire [31:0] rdata_in,
  input wire ack_in,
  input wire err_in
);
  logic bad_ok = 1'b0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    int n;
    {q, e, ok} = {32'h0, 2'b01};
    if (w && a == 16'h6850 && drive_en_in && !bad_ok) return;
    @(posedge clk_in);
    #1;
    {addr_out, wr_out, rd_out, wdata_out} = {a, w, !w, d};
    @(posedge clk_in);
    #1;
    // stale data is inverted so nothing can lean on it
    {wr_out, rd_out, wdata_out} = {2'b00, ~d};
    n = 0;
    while (!ack_in && n < 4) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    {ok, q, e} = {ack_in, rdata_in, err_in};
  endtask
endmodule // svm_master

//--- tb/svm_top_assertions.sv
// Purpose: port checks for svm_top
// Assumes: one clock, async active-low reset
// Notes: control ticks are not visible here, so supervision timing is judged by the bench
`timescale 1ns/1ps
module svm_chk (
  // clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // parameter port
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_wdata_in,
  input wire [31:0] reg_rdata_out,
  input wire reg_ack_out,
  input wire reg_err_out,
  // status
  input wire drive_enabled_in,
  input wire alarm_clear_in,
  input wire following_alarm_out,
  input wire limit_alarm_out,
  input wire [15:0] vel_kp_out,
  input wire [15:0] vel_filter_bw_out,
  input wire [15:0] smooth_filter_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_req;
    reg_wr_in || reg_rd_in;
  endsequence
  sequence s_filt_wr;
    reg_wr_in && reg_addr_in == 16'h6350;
  endsequence
  AST_ACK: assert property (s_req |=> reg_ack_out) else $error("access not acked");
  AST_NO_ACK: assert property (!(reg_wr_in || reg_rd_in) |=> !reg_ack_out)
    else $error("ack without access");
  AST_ERR_ACK: assert property (reg_err_out |-> reg_ack_out) else $error("err without ack");
  AST_ERR_RDATA: assert property (reg_err_out && $past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("unmapped read data not zero");
  AST_KP: assert property (reg_wr_in && reg_addr_in == 16'h6310 |=>
    vel_kp_out == $past(reg_wdata_in[15:0])) else $error("kp not updated");
  AST_FILT: assert property (s_filt_wr |-> ##2
    vel_filter_bw_out == $past(reg_wdata_in[7:0], 2) * 16'd20 + 16'd100)
    else $error("filter bandwidth wrong");
  AST_SMOOTH: assert property (reg_wr_in && reg_addr_in == 16'h6850 && drive_enabled_in |=>
    $stable(smooth_filter_out)) else $error("smoothing changed while enabled");
  AST_FOLLOW: assert property (following_alarm_out && !alarm_clear_in |=>
    following_alarm_out) else $error("following alarm dropped");
  AST_LIMIT: assert property (limit_alarm_out && !alarm_clear_in |=> limit_alarm_out)
    else $error("limit alarm dropped");
endmodule // svm_chk
bind svm_top svm_chk chk_u (.*);

//--- tb/svm_top_tb.sv
// Purpose: self-checking bench for svm_top
// Assumes: CTRL_CYCLES of 8, so a control tick every 8 clocks
// Notes: tick waits keep one tick of slack since the tick phase is hidden
`timescale 1ns/1ps
module svm_top_tb;
  localparam int CC = 8;
  logic core_clk_in = 0, rst_n_in = 0, drive_enabled_in = 0, pos_limit_in = 0;
  logic neg_limit_in = 0, home_found_in = 0, homing_active_in = 0, home_trigger_in = 0;
  logic home_done_in = 0, alarm_clear_in = 0, e, ok;
  logic [31:0] cmd_pos_in = 0, act_pos_in = 0, target_speed_in = 0, act_speed_in = 0;
  logic [31:0] target_accel_in = 0, q, d, ofs;
  wire [15:0] reg_addr_in, vel_kp_out, vel_filter_bw_out, smooth_filter_out;
  wire reg_wr_in, reg_rd_in, reg_ack_out, reg_err_out, following_alarm_out, pos_reached_out;
  wire speed_reached_out, zero_speed_out, limit_alarm_out, soft_limit_pos_out, soft_limit_neg_out;
  wire [31:0] reg_wdata_in, reg_rdata_out, home_speed_out, home_target_pos_out;
  wire [31:0] report_pos_out, pos_loop_cmd_out;
  wire [7:0] home_method_out;
  wire [21:0] vel_ki_out;
  int errors = 0, num_checks = 0;
  logic [15:0] ra [23] = '{16'h0980, 16'h0990, 16'h1990, 16'h3800, 16'h3900, 16'h4100,
    16'h4410, 16'h4420, 16'h4d00, 16'h5010, 16'h5020, 16'h5050, 16'h5200, 16'h6310,
    16'h6320, 16'h6350, 16'h6370, 16'h63a0, 16'h6440, 16'h6810, 16'h6820, 16'h6830, 16'h6850};
  int rw [23] = '{16, 8, 16, 32, 32, 32, 32, 32, 8, 32, 32, 8, 32, 16, 16, 8, 16, 32, 16, 16,
    16, 16, 16};
  logic [31:0] rv [23] = '{32'h3, 32'h1, 32'ha, 32'h80000, 32'h147, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h12c, 32'h64, 32'h0, 32'h32, 32'h4, 32'h0, 32'hf0, 32'h2, 32'h2bb0c, 32'ha, 32'ha,
    32'h64, 32'h7fff, 32'h1};
  logic [31:0] mdl [23];
  svm_top #(.CTRL_CYCLES(CC)) dut_u (.*);
  svm_master mst_u (.clk_in(core_clk_in), .drive_en_in(drive_enabled_in),
    .addr_out(reg_addr_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in), .wdata_out(reg_wdata_in),
    .rdata_in(reg_rdata_out), .ack_in(reg_ack_out), .err_in(reg_err_out));
  always #2 core_clk_in = ~core_clk_in;
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] v);
    mst_u.xfer(1'b1, a, v, q, e, ok);
    chk("wr ack", {31'h0, ok}, 32'h1);
    if (!ok) complete_run();
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] x, logic xe);
    mst_u.xfer(1'b0, a, 32'h0, q, e, ok);
    chk("rd ack", {31'h0, ok}, 32'h1);
    if (!ok) complete_run();
    chk("rdata", q, x);
    chk("err", {31'h0, e}, {31'h0, xe});
  endtask
  task automatic tk(int n);
    repeat (n * CC) @(posedge core_clk_in);
    #1;
  endtask
  task automatic do_reset;
    rst_n_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    mdl = rv;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32));
    target_accel_in = $urandom_range(0, 255);
    target_speed_in = $urandom_range(0, 255);
    {cmd_pos_in, act_pos_in} = {32'd7, 32'd4};
    do_reset();
    tk(3);
    chk("loop", pos_loop_cmd_out, 30 + target_speed_in * 100 / 128 + target_accel_in * 32767 / 32768);
    for (int i = 0; i < 23; i++) rd(ra[i], rv[i], 1'b0);
    rd(16'h0a00, 32'h0, 1'b1);
    for (int i = 0; i < 23; i++) begin
      d = $urandom & 32'((64'h1 << rw[i]) - 64'h1);
      wr(ra[i], d);
      mdl[i] = d;
    end
    for (int i = 0; i < 23; i++) rd(ra[i], mdl[i], 1'b0);
    chk("ki", vel_ki_out, ((mdl[14] << 5) + mdl[16]) & 32'h3fffff);
    chk("bw", vel_filter_bw_out, mdl[15] * 20 + 100);
    chk("method", home_method_out, mdl[8]);
    {drive_enabled_in, mst_u.bad_ok} = 2'b11;
    wr(16'h6850, ~mdl[22] & 32'hffff);
    rd(16'h6850, mdl[22], 1'b0);
    {drive_enabled_in, mst_u.bad_ok} = 2'b00;
    do_reset();
    wr(16'h3800, 32'd100);
    {cmd_pos_in, act_pos_in, act_speed_in} = {32'd1000, 32'd900, 32'd1040};
    tk(2);
    chk("follow at limit", following_alarm_out, 0);
    act_pos_in = 32'd1101;
    tk(2);
    chk("follow over", following_alarm_out, 1);
    act_pos_in = 32'd980;
    alarm_clear_in = 1'b1;
    tk(1);
    alarm_clear_in = 1'b0;
    tk(1);
    chk("follow clear", following_alarm_out, 0);
    wr(16'h1990, 32'd2);
    wr(16'h3900, 32'd10);
    tk(2);
    act_pos_in = 32'd995;
    tk(2);
    chk("reach early", pos_reached_out, 0);
    tk(3);
    chk("reach", pos_reached_out, 1);
    act_pos_in = 32'd1020;
    tk(2);
    act_pos_in = 32'd995;
    chk("reach left", pos_reached_out, 0);
    tk(2);
    chk("reach restart", pos_reached_out, 0);
    wr(16'h6440, 32'd1);
    wr(16'h63a0, 32'd50);
    {target_speed_in, act_speed_in} = {32'd1000, -32'sd2};
    tk(1);
    chk("zero early", zero_speed_out, 0);
    tk(3);
    chk("zero", zero_speed_out, 1);
    chk("spd far", speed_reached_out, 0);
    act_speed_in = 32'd1040;
    tk(2);
    chk("zero off", zero_speed_out, 0);
    chk("spd in", speed_reached_out, 1);
    act_speed_in = 32'd1060;
    tk(2);
    chk("spd out", speed_reached_out, 0);
    home_found_in = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(16'h0990, i / 2);
      {pos_limit_in, neg_limit_in} = {i != 1, i != 0};
      tk(2);
      chk("limit", limit_alarm_out, i < 2);
      {pos_limit_in, neg_limit_in, alarm_clear_in} = 3'b001;
      tk(1);
      alarm_clear_in = 1'b0;
      tk(1);
    end
    wr(16'h4410, 32'd400);
    wr(16'h4420, -32'sd400);
    tk(2);
    chk("soft", {soft_limit_pos_out, soft_limit_neg_out}, 2'b10);
    ofs = $urandom_range(0, 999) - 500;
    wr(16'h4100, ofs);
    {homing_active_in, act_pos_in} = {1'b1, 32'd500};
    tk(1);
    chk("ramp", home_speed_out > 0 && home_speed_out <= 50, 1);
    tk(4);
    chk("search", home_speed_out, 100);
    home_trigger_in = 1'b1;
    tk(1);
    home_trigger_in = 1'b0;
    chk("trig target", home_target_pos_out, 500 + ofs);
    tk(6);
    chk("turn", home_speed_out, 300);
    for (int m = 0; m < 2; m++) begin
      wr(16'h5050, m);
      home_done_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      home_done_in = 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1;
      chk("report", report_pos_out, m ? -ofs : 32'h0);
    end
    homing_active_in = 1'b0;
    tk(7);
    chk("idle speed", home_speed_out, 0);
    complete_run();
  end
endmodule // svm_top_tb
